// ### common/rsho_consts.vh
// Purpose: Shared constants of the reference switchover and holdover control.
// Assumes: One clock, the PLL feedback clock, at 50 MHz.
// Notes:   Offsets are register-map byte addresses on the serial port.
`ifndef RSHO_CONSTS_VH
`define RSHO_CONSTS_VH

// Register offsets.
`define RSHO_ADDR_VCO_CAL_CTRL  8'h0E
`define RSHO_ADDR_VCO_BAND_OVR  8'h10
`define RSHO_ADDR_SWO_MODE      8'h29

// Field positions.
`define RSHO_CAL_CMD_BIT        7
`define RSHO_CAL_SPI_EN_BIT     2
`define RSHO_BAND_SPI_EN_BIT    0
`define RSHO_MODE_HI            7
`define RSHO_MODE_LO            6

// Reset values.
`define RSHO_RST_CAL_CTRL       8'h00
`define RSHO_RST_BAND_OVR       8'h00
`define RSHO_RST_SWO_MODE       8'h00

// Switchover mode codes.
`define RSHO_MODE_REVERT        2'h0
`define RSHO_MODE_NONREVERT     2'h1
`define RSHO_MODE_MAN_PRI       2'h2
`define RSHO_MODE_MAN_SEC       2'h3

// Input selection codes.
`define RSHO_SEL_NONE           2'h0
`define RSHO_SEL_PRI            2'h1
`define RSHO_SEL_SEC            2'h2
`define RSHO_SEL_CRYSTAL_IN           2'h3

// Feedback divider limits.
`define RSHO_FBDIV_MIN          20'h00020
`define RSHO_FBDIV_LOW_BW       20'h04000

// Timing: calibration time in ns and detector window in ns at 20 ns per cycle.
`define RSHO_CLK_PERIOD_NS      20
`define RSHO_CAL_TIME_NS        40000
`define RSHO_CAL_CYCLES         ((`RSHO_CAL_TIME_NS) / (`RSHO_CLK_PERIOD_NS))
`define RSHO_DET_TIME_NS        2000
`define RSHO_DET_CYCLES         ((`RSHO_DET_TIME_NS) / (`RSHO_CLK_PERIOD_NS))

`endif

// ### core/rsho_presence_det.v
// Purpose: Signal presence detector for one clock input.
// Assumes: Input is asynchronous to clk; clk is the PLL feedback clock.
// Notes:   Present means an edge was seen within the last detector window.
`timescale 1ns/1ps
`include "rsho_consts.vh"

module rsho_presence_det (
	// Clock and reset.
	input  wire clk,
	input  wire rst,
	// Monitored input and result.
	input  wire sig_in,
	output reg  present
);

	reg        sync_a;
	reg        sync_b;
	reg        last;
	reg [11:0] idle_cnt;

	// Two-stage synchroniser, then an edge reference stage.
	// It keeps tracking the pin during reset, so a pin idling high gives no false edge.
	always @(posedge clk) begin
		sync_a <= sig_in;
		sync_b <= sync_a;
		last   <= sync_b;
	end

	// Any edge restarts the window; a full window without one means absent.
	always @(posedge clk) begin
		if (rst) begin
			idle_cnt <= 12'h000;
			present  <= 1'b0;
		end else if (sync_b != last) begin
			idle_cnt <= 12'h000;
			present  <= 1'b1;
		end else if (idle_cnt == `RSHO_DET_CYCLES - 1) begin
			present  <= 1'b0;
		end else begin
			idle_cnt <= idle_cnt + 12'h001;
		end
	end

endmodule // rsho_presence_det

// ### core/rsho_ctrl.v
// Purpose: Reference selection, holdover, VCO calibration and divider control.
// Assumes: clk is the PLL feedback clock; register port is the serial controller's side.
// Notes:   Contract
`timescale 1ns/1ps
`include "rsho_consts.vh"

module rsho_ctrl (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst,
	// Reference pins.
	input  wire        primary_ref_in,
	input  wire        secondary_ref_in,
	input  wire        crystal_in,
	input  wire        force_secondary_pin,
	// Register port.
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// Pin-decoder function bits.
	input  wire [6:0]  pin_vco_band,
	input  wire [6:0]  cal_band_result,
	input  wire [19:0] fb_div_in,
	input  wire        pri_div5_en,
	input  wire        pri_dbl_en,
	input  wire        sec_div5_en,
	input  wire        sec_dbl_en,
	// Status and control outputs.
	output reg  [1:0]  input_sel,
	output reg         holdover,
	output reg         pri_present,
	output reg         sec_present,
	output reg         crystal_in_present,
	output reg         cal_busy,
	output wire        outputs_static,
	output wire [6:0]  vco_band,
	output reg  [19:0] fb_div,
	output reg         fb_div_rejected,
	output reg         loop_filter_low_bw,
	output reg         path_div5,
	output reg         path_dbl
);

	localparam ST_CAL_IDLE = 1'b0;
	localparam ST_CAL_RUN  = 1'b1;

	wire        det_pri;
	wire        det_sec;
	wire        det_crystal_in;
	reg  [7:0]  cal_ctrl;
	reg  [7:0]  band_ovr;
	reg  [7:0]  swo_mode;
	reg  [6:0]  cal_band;
	reg         cal_state;
	reg  [11:0] cal_cnt;
	reg  [1:0]  next_sel;
	wire [1:0]  mode;
	wire        cal_cmd;

	assign mode = swo_mode[`RSHO_MODE_HI:`RSHO_MODE_LO];

	// One detector per input, all sampled on the feedback clock.
	rsho_presence_det u_det_pri (
		.clk     (clk),
		.rst     (rst),
		.sig_in  (primary_ref_in),
		.present (det_pri)
	);
	rsho_presence_det u_det_sec (
		.clk     (clk),
		.rst     (rst),
		.sig_in  (secondary_ref_in),
		.present (det_sec)
	);
	rsho_presence_det u_det_crystal_in (
		.clk     (clk),
		.rst     (rst),
		.sig_in  (crystal_in),
		.present (det_crystal_in)
	);

	// Calibration command counts only when calibration control is already enabled.
	assign cal_cmd = reg_wr && (reg_addr == `RSHO_ADDR_VCO_CAL_CTRL)
		&& reg_wdata[`RSHO_CAL_CMD_BIT] && cal_ctrl[`RSHO_CAL_SPI_EN_BIT];

	// Register writes; the command bit is never stored.
	always @(posedge clk) begin
		if (rst) begin
			cal_ctrl <= `RSHO_RST_CAL_CTRL;
			band_ovr <= `RSHO_RST_BAND_OVR;
			swo_mode <= `RSHO_RST_SWO_MODE;
		end else if (reg_wr) begin
			case (reg_addr)
				`RSHO_ADDR_VCO_CAL_CTRL: begin
					cal_ctrl <= {1'b0, reg_wdata[6:0]};
				end
				`RSHO_ADDR_VCO_BAND_OVR: begin
					band_ovr <= reg_wdata;
				end
				`RSHO_ADDR_SWO_MODE: begin
					swo_mode <= reg_wdata;
				end
				default: begin
					cal_ctrl <= cal_ctrl;
				end
			endcase
		end
	end

	// Register reads; calibration progress shows in the command bit.
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`RSHO_ADDR_VCO_CAL_CTRL: reg_rdata <= {cal_busy, cal_ctrl[6:0]};
				`RSHO_ADDR_VCO_BAND_OVR: reg_rdata <= band_ovr;
				`RSHO_ADDR_SWO_MODE:     reg_rdata <= swo_mode;
				default:                 reg_rdata <= 8'h00;
			endcase
		end
	end

	// Calibration sequencer: starts at reset, or on a command, runs a fixed time.
	always @(posedge clk) begin
		if (rst) begin
			cal_state <= ST_CAL_RUN;
			cal_cnt   <= 12'h000;
			cal_busy  <= 1'b1;
			cal_band  <= 7'h00;
		end else begin
			case (cal_state)
				ST_CAL_IDLE: begin
					if (cal_cmd) begin
						cal_state <= ST_CAL_RUN;
						cal_cnt   <= 12'h000;
						cal_busy  <= 1'b1;
					end
				end
				ST_CAL_RUN: begin
					if (cal_cnt == `RSHO_CAL_CYCLES - 1) begin
						cal_state <= ST_CAL_IDLE;
						cal_busy  <= 1'b0;
						cal_band  <= cal_band_result;
					end else begin
						cal_cnt <= cal_cnt + 12'h001;
					end
				end
				default: begin
					cal_state <= ST_CAL_IDLE;
				end
			endcase
		end
	end

	// Drivers stay at a dc level for the whole calibration.
	assign outputs_static = cal_busy;

	// Band mux switches the instant the band enable in calibration control is set.
	assign vco_band = cal_ctrl[`RSHO_BAND_SPI_EN_BIT] ? band_ovr[7:1] : cal_band;

	// Next input selection from presence, mode and the force pin.
	always @* begin
		next_sel = `RSHO_SEL_NONE;
		case (mode)
			`RSHO_MODE_REVERT: begin
				if (force_secondary_pin && det_sec)
					next_sel = `RSHO_SEL_SEC;
				else if (det_pri)
					next_sel = `RSHO_SEL_PRI;
				else if (det_sec)
					next_sel = `RSHO_SEL_SEC;
				else if (det_crystal_in)
					next_sel = `RSHO_SEL_CRYSTAL_IN;
			end
			`RSHO_MODE_NONREVERT: begin
				if (force_secondary_pin && det_sec)
					next_sel = `RSHO_SEL_SEC;
				else if (input_sel == `RSHO_SEL_SEC && det_sec)
					next_sel = `RSHO_SEL_SEC;
				else if (det_pri)
					next_sel = `RSHO_SEL_PRI;
				else if (det_sec)
					next_sel = `RSHO_SEL_SEC;
				else if (det_crystal_in)
					next_sel = `RSHO_SEL_CRYSTAL_IN;
			end
			`RSHO_MODE_MAN_PRI: begin
				if (force_secondary_pin && det_sec)
					next_sel = `RSHO_SEL_SEC;
				else if (det_pri)
					next_sel = `RSHO_SEL_PRI;
			end
			`RSHO_MODE_MAN_SEC: begin
				if (det_sec)
					next_sel = `RSHO_SEL_SEC;
			end
			default: begin
				next_sel = `RSHO_SEL_NONE;
			end
		endcase
	end

	// Registered selection and detector status, so the mux switches cleanly.
	always @(posedge clk) begin
		if (rst) begin
			input_sel    <= `RSHO_SEL_NONE;
			holdover     <= 1'b0;
			pri_present  <= 1'b0;
			sec_present  <= 1'b0;
			crystal_in_present <= 1'b0;
		end else begin
			input_sel    <= next_sel;
			holdover     <= (next_sel == `RSHO_SEL_CRYSTAL_IN);
			pri_present  <= det_pri;
			sec_present  <= det_sec;
			crystal_in_present <= det_crystal_in;
		end
	end

	// Feedback divider: values below the floor are refused and the old one kept.
	always @(posedge clk) begin
		if (rst) begin
			fb_div             <= `RSHO_FBDIV_MIN;
			fb_div_rejected    <= 1'b0;
			loop_filter_low_bw <= 1'b0;
		end else begin
			fb_div_rejected <= (fb_div_in < `RSHO_FBDIV_MIN);
			if (fb_div_in >= `RSHO_FBDIV_MIN) begin
				fb_div             <= fb_div_in;
				loop_filter_low_bw <= (fb_div_in >= `RSHO_FBDIV_LOW_BW);
			end
		end
	end

	// Prescaler and doubler settings of the path now feeding the phase detector.
	always @(posedge clk) begin
		if (rst) begin
			path_div5 <= 1'b0;
			path_dbl  <= 1'b0;
		end else if (next_sel == `RSHO_SEL_PRI) begin
			path_div5 <= pri_div5_en;
			path_dbl  <= pri_dbl_en;
		end else if (next_sel == `RSHO_SEL_SEC) begin
			path_div5 <= sec_div5_en;
			path_dbl  <= sec_dbl_en;
		end else begin
			path_div5 <= 1'b0;
			path_dbl  <= 1'b0;
		end
	end

endmodule // rsho_ctrl

// ### verif/rsho_ctrl_monitor.sv
// Purpose: Port checker for the reference switchover control.
// Assumes: One clock and a synchronous active-high reset.
// Notes:   The mode field is mirrored from register writes.
`timescale 1ns/1ps
module rsho_ctrl_monitor (
	// Clock and reset.
	input wire        clk,
	input wire        rst,
	// Watched ports.
	input wire        pri_present,
	input wire        sec_present,
	input wire        crystal_in_present,
	input wire        force_secondary_pin,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire [1:0]  input_sel,
	input wire        holdover,
	input wire        cal_busy,
	input wire        outputs_static,
	input wire [19:0] fb_div_in,
	input wire [19:0] fb_div,
	input wire        fb_div_rejected,
	input wire        loop_filter_low_bw
);
	reg [1:0]  mode;
	reg [11:0] busy_cnt;
	// Tracks the switchover mode written over the register port.
	always @(posedge clk) begin
		if (rst)
			mode <= 2'h0;
		else if (reg_wr && reg_addr == 8'h29)
			mode <= reg_wdata[7:6];
	end
	// Counts the cycles of the calibration now running.
	always @(posedge clk) begin
		if (rst)
			busy_cnt <= 12'h000;
		else if (cal_busy)
			busy_cnt <= busy_cnt + 12'h001;
		else
			busy_cnt <= 12'h000;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Selections are judged once their causes have held for two cycles.
	rev_pri_a: assert property ((mode == 2'h0 && pri_present && !force_secondary_pin)[*2]
		|-> input_sel == 2'h1) else $error("Revertive mode did not pick primary.");
	hold_crystal_in_a: assert property ((!mode[1] && !pri_present && !sec_present && crystal_in_present)[*2]
		|-> input_sel == 2'h3) else $error("Holdover did not pick crystal.");
	man_nohold_a: assert property (mode[1][*2] |-> input_sel != 2'h3)
		else $error("Manual mode picked crystal.");
	man_pri_a: assert property ((mode == 2'h2 && pri_present && !force_secondary_pin)[*2]
		|-> input_sel == 2'h1) else $error("Manual primary not picked.");
	force_sec_a: assert property ((sec_present && force_secondary_pin)[*2]
		|-> input_sel == 2'h2) else $error("Force pin did not pick secondary.");
	nonrev_stay_a: assert property ((mode == 2'h1 && sec_present)[*2] ##0 $past(input_sel) == 2'h2
		|-> input_sel == 2'h2) else $error("Nonrevertive mode left secondary.");
	none_sel_a: assert property ((!pri_present && !sec_present && !crystal_in_present)[*2]
		|-> input_sel == 2'h0) else $error("Selection made with no input.");
	cal_start_a: assert property ($fell(rst) |-> cal_busy && outputs_static)
		else $error("Calibration not running after reset.");
	static_out_a: assert property (outputs_static == cal_busy)
		else $error("Output hold differs from calibration.");
	cal_len_a: assert property ($fell(outputs_static) |-> busy_cnt == 12'h7D0)
		else $error("Output hold did not last the calibration time.");
	div_reject_a: assert property (fb_div_in < 20'h00020 |=> fb_div_rejected && $stable(fb_div))
		else $error("Small divider not refused.");
	div_filter_a: assert property (fb_div_in >= 20'h00020 |=> fb_div == $past(fb_div_in)
		&& loop_filter_low_bw == ($past(fb_div_in) >= 20'h04000)) else $error("Divider or filter wrong.");
	// Main scenarios.
	cover property (holdover);
	cover property (mode == 2'h1 && input_sel == 2'h2 && pri_present);
	cover property ($fell(cal_busy));
endmodule // rsho_ctrl_monitor

bind rsho_ctrl rsho_ctrl_monitor mon (.clk(clk), .rst(rst), .pri_present(pri_present),
	.sec_present(sec_present), .crystal_in_present(crystal_in_present),
	.force_secondary_pin(force_secondary_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .input_sel(input_sel), .holdover(holdover), .cal_busy(cal_busy),
	.outputs_static(outputs_static), .fb_div_in(fb_div_in), .fb_div(fb_div),
	.fb_div_rejected(fb_div_rejected), .loop_filter_low_bw(loop_filter_low_bw));

// ### verif/rsho_ref_src.sv
// Purpose: Reference and crystal clock sources.
// Assumes: Sources run well below the detector window.
// Notes:   A stopped source holds its level still.
`timescale 1ns/1ps
module rsho_ref_src (
	// Clock and source enables.
	input wire       clk,
	input wire [2:0] src_on,
	// Primary, secondary and crystal clocks.
	output reg [2:0] src_clk
);
	reg [3:0] div = 4'h0;
	initial src_clk = 3'h0;
	// Toggles each running source once every sixteen cycles.
	always @(posedge clk) begin
		div <= div + 4'h1;
		if (div == 4'h7)
			src_clk <= src_clk ^ src_on;
	end
endmodule // rsho_ref_src

// ### verif/rsho_ctrl_bench.sv
// Purpose: Self-checking bench of the switchover control.
// Assumes: 50 MHz clock, synchronous reset.
// Notes:   Sources are started and stopped through the source model.
`timescale 1ns/1ps
module rsho_ctrl_bench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [2:0]  src_on = 3'h0;
	reg         fsel = 1'b0;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg  [19:0] fb_div_in = 20'h04000;
	reg  [3:0]  cfg = 4'h9;
	reg  [6:0]  cal_res = 7'h5A;
	wire [2:0]  src_clk;
	wire [7:0]  reg_rdata;
	wire [1:0]  input_sel;
	wire [6:0]  vco_band;
	wire [19:0] fb_div;
	wire        holdover, cal_busy, outputs_static, rej, lbw, div5, dbl;
	integer     err_count = 0;
	integer     checked = 0;
	integer     cyc = 0;
	rsho_ref_src src (.clk(clk), .src_on(src_on), .src_clk(src_clk));
	rsho_ctrl dut (.clk(clk), .rst(rst), .primary_ref_in(src_clk[0]),
		.secondary_ref_in(src_clk[1]), .crystal_in(src_clk[2]), .force_secondary_pin(fsel),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_vco_band(7'h00), .cal_band_result(cal_res),
		.fb_div_in(fb_div_in), .pri_div5_en(cfg[0]), .pri_dbl_en(cfg[1]),
		.sec_div5_en(cfg[2]), .sec_dbl_en(cfg[3]), .input_sel(input_sel),
		.holdover(holdover), .pri_present(), .sec_present(), .crystal_in_present(),
		.cal_busy(cal_busy), .outputs_static(outputs_static), .vco_band(vco_band),
		.fb_div(fb_div), .fb_div_rejected(rej), .loop_filter_low_bw(lbw),
		.path_div5(div5), .path_dbl(dbl));
	// Clock generator.
	always #10 clk = ~clk;
	task final_report;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			final_report;
		end
	end
	task chk(input string n, input [19:0] seen, input [19:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0s expected %h seen %h", n, exp, seen);
		end
	endtask
	task w(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		w(0);
		chk("rdata", reg_rdata, e);
	endtask
	task sel(input [7:0] s, input [1:0] e);
		@(posedge clk) src_on <= s[2:0];
		w(150);
		chk("input_sel", input_sel, e);
	endtask
	task t_reset;
		chk("cal_busy", cal_busy, 1);
		chk("outputs_static", outputs_static, 1);
		rd(8'h29, 8'h00);
		w(2010);
		chk("cal_busy", cal_busy, 0);
		chk("vco_band", vco_band, 7'h5A);
		$display("reset test done");
	endtask
	task t_auto;
		sel(7, 1);
		chk("path_div5", {dbl, div5}, 1);
		sel(6, 2);
		chk("path_dbl", {dbl, div5}, 2);
		sel(7, 1);
		sel(4, 3);
		chk("holdover", holdover, 1);
		sel(0, 0);
		sel(2, 2);
		wr(8'h29, 8'h40);
		sel(5, 1);
		sel(7, 1);
		sel(6, 2);
		sel(7, 2);
		sel(5, 1);
		$display("automatic test done");
	endtask
	task t_manual;
		wr(8'h29, 8'h80);
		sel(5, 1);
		sel(6, 0);
		@(posedge clk) fsel <= 1'b1;
		sel(7, 2);
		@(posedge clk) fsel <= 1'b0;
		wr(8'h29, 8'hC0);
		sel(7, 2);
		sel(4, 0);
		wr(8'h29, 8'h00);
		sel(4, 3);
		$display("manual test done");
	endtask
	task t_cal;
		wr(8'h0E, 8'h84);
		w(2);
		chk("cal_busy", cal_busy, 0);
		wr(8'h0E, 8'h04);
		@(posedge clk) cal_res <= 7'h33;
		wr(8'h0E, 8'h84);
		w(0);
		chk("outputs_static", outputs_static, 1);
		rd(8'h0E, 8'h84);
		w(2010);
		chk("vco_band", vco_band, 7'h33);
		wr(8'h10, 8'h4B);
		w(1);
		chk("vco_band", vco_band, 7'h33);
		wr(8'h0E, 8'h05);
		w(1);
		chk("vco_band", vco_band, 7'h25);
		rd(8'h10, 8'h4B);
		rd(8'h11, 8'h00);
		$display("calibration test done");
	endtask
	task t_div;
		@(posedge clk) fb_div_in <= 20'h0001F;
		w(2);
		chk("fb_div_rejected", rej, 1);
		chk("fb_div", fb_div, 20'h04000);
		@(posedge clk) fb_div_in <= 20'h00020;
		w(2);
		chk("fb_div_rejected", rej, 0);
		chk("fb_div", fb_div, 20'h00020);
		chk("loop_filter_low_bw", lbw, 0);
		@(posedge clk) fb_div_in <= 20'h03FFF;
		w(2);
		chk("loop_filter_low_bw", lbw, 0);
		@(posedge clk) fb_div_in <= 20'h04000;
		w(2);
		chk("loop_filter_low_bw", lbw, 1);
		@(posedge clk) fb_div_in <= 20'hFFFFF;
		w(2);
		chk("loop_filter_low_bw", lbw, 1);
		chk("fb_div", fb_div, 20'hFFFFF);
		$display("divider test done");
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		w(0);
		t_reset;
		t_auto;
		t_manual;
		t_cal;
		t_div;
		final_report;
	end
endmodule // rsho_ctrl_bench
